// >>> core/ialu_core.sv
// integer execution datapath: logic, shifts, multiply/divide, circular add, find-first
// How it works
// RL1 - set-less-unsigned writes 1 to destination when a below b, else 0
// RL2 - and, or, xor, nor combine a and b bitwise into destination
// RL3 - constant left shift of b by shift amount, zeros fill low bits
// RL4 - constant logical right shift of b, zeros fill high bits
// RL5 - constant arithmetic right shift of b, sign bit fills high bits
// RL6 - variable shifts use a's low five bits as count
// RL7 - signed multiply puts 64-bit product into upper and lower registers
// RL8 - unsigned multiply puts 64-bit product into upper and lower registers
// RL9 - signed divide: quotient to lower, remainder to upper
// RL10 - unsigned divide: quotient to lower, remainder to upper
// RL11 - read upper or read lower copies that register into destination
// RL12 - write upper and write lower load the register from source a
// RL13 - result registers are shared with translation buffer access, results overwrite
// RL14 - circular add: sign-extended immediate plus a, bits at and above mask kept from a
// RL15 - find-first scans a from msb for first one or first zero
// RL16 - find-first with no match returns all ones
// RL17 - product high half to upper register, low half to lower
// RL18 - returned bit number is absolute, 31 at msb, 0 at lsb
`timescale 1ns/1ps
`default_nettype none
`include "ialu_params.svh"
module ialu_core (
  input wire logic clock,
  input wire logic srst,
  input wire logic op_valid,
  input wire ialu_pkg::ialu_op_t op_code,
  input wire logic [31:0] source_a,
  input wire logic [31:0] source_b,
  input wire logic [4:0] shift_amount_field,
  input wire logic [15:0] immediate,
  input wire logic [4:0] circular_mask,
  input wire logic tlb_write_upper,
  input wire logic tlb_write_lower,
  input wire logic [31:0] tlb_write_data,
  output logic busy,
  output logic result_valid,
  output logic result_to_dest,
  output logic result_to_source_b,
  output logic [31:0] result_data,
  output logic [31:0] upper_result,
  output logic [31:0] lower_result
);
  logic busy_q;
  logic busy_d;
  logic result_valid_q;
  logic result_valid_d;
  logic to_dest_q;
  logic to_dest_d;
  logic to_source_b_q;
  logic to_source_b_d;
  logic [31:0] result_q;
  logic [31:0] result_d;
  logic [31:0] upper_q;
  logic [31:0] upper_d;
  logic [31:0] lower_q;
  logic [31:0] lower_d;
  logic [31:0] first_index;
  logic [31:0] circ_result;
  logic [31:0] low_mask;
  logic div_done;
  logic [31:0] div_quotient;
  logic [31:0] div_remainder;

  // requests are taken only while no divide runs
  wire take = op_valid & ~busy_q;

  wire is_slt = op_code == ialu_pkg::ialu_op_unsigned_less_compare;
  wire is_and = op_code == ialu_pkg::ialu_op_and;
  wire is_or = op_code == ialu_pkg::ialu_op_or;
  wire is_xor = op_code == ialu_pkg::ialu_op_exclusive_or_op;
  wire is_nor = op_code == ialu_pkg::ialu_op_not_or_op;
  wire is_sll_c = op_code == ialu_pkg::ialu_op_shift_left_const;
  wire is_srl_c = op_code == ialu_pkg::ialu_op_logical_right_const;
  wire is_sra_c = op_code == ialu_pkg::ialu_op_arith_right_const;
  wire is_sll_v = op_code == ialu_pkg::ialu_op_shift_left_var;
  wire is_srl_v = op_code == ialu_pkg::ialu_op_logical_right_var;
  wire is_sra_v = op_code == ialu_pkg::ialu_op_arith_right_var;
  wire is_mul_s = op_code == ialu_pkg::ialu_op_signed_product_op;
  wire is_mul_u = op_code == ialu_pkg::ialu_op_unsigned_product_op;
  wire is_div_s = op_code == ialu_pkg::ialu_op_signed_quotient_op;
  wire is_div_u = op_code == ialu_pkg::ialu_op_unsigned_quotient_op;
  wire is_rd_up = op_code == ialu_pkg::ialu_op_read_upper_result;
  wire is_rd_lo = op_code == ialu_pkg::ialu_op_read_lower_result;
  wire is_wr_up = op_code == ialu_pkg::ialu_op_write_upper_result;
  wire is_wr_lo = op_code == ialu_pkg::ialu_op_write_lower_result;
  wire is_circ = op_code == ialu_pkg::ialu_op_circular_add_imm;
  wire is_ff_one = op_code == ialu_pkg::ialu_op_find_first_one;
  wire is_ff_zero = op_code == ialu_pkg::ialu_op_find_first_zero;

  wire is_var_shift = is_sll_v | is_srl_v | is_sra_v;
  wire is_mul = is_mul_s | is_mul_u;
  wire is_div = is_div_s | is_div_u;
  wire div_start = take & is_div;

  // comparison and bitwise group
  wire a_below_b = source_a < source_b; // RL1
  wire [31:0] less_word = a_below_b ? `IALU_LESS_TRUE : `IALU_RST_WORD; // RL1
  wire [31:0] and_word = source_a & source_b; // RL2
  wire [31:0] or_word = source_a | source_b; // RL2
  wire [31:0] xor_word = source_a ^ source_b; // RL2
  wire [31:0] nor_word = ~(source_a | source_b); // RL2

  // one shifter serves constant and variable counts
  wire [4:0] shift_count = is_var_shift ? source_a[4:0] : shift_amount_field; // RL6
  wire [31:0] shl_word = source_b << shift_count; // RL3
  wire [31:0] shr_word = source_b >> shift_count; // RL4
  wire [31:0] sar_word = 32'($signed(source_b) >>> shift_count); // RL5

  // full products, high half to upper
  wire signed [63:0] prod_signed = $signed(source_a) * $signed(source_b); // RL7
  wire [63:0] prod_unsigned = {32'h00000000, source_a} * {32'h00000000, source_b}; // RL8
  wire [63:0] prod_word = is_mul_s ? prod_signed : prod_unsigned; // RL17

  // circular add keeps a's bits at and above the mask boundary
  wire [31:0] imm_ext = {{16{immediate[15]}}, immediate}; // RL14
  wire [31:0] circ_sum = 32'(source_a + imm_ext); // RL14

  genvar gi;
  generate
    for (gi = 0; gi < `IALU_WORD; gi = gi + 1) begin : g_circ
      assign low_mask[gi] = 6'(gi) < {1'b0, circular_mask}; // RL14
      assign circ_result[gi] = low_mask[gi] ? circ_sum[gi] : source_a[gi]; // RL14
    end
  endgenerate

  // find-first: the highest hit wins, no hit leaves all ones
  wire [31:0] scan_word = is_ff_zero ? ~source_a : source_a; // RL15

  always_comb begin
    first_index = `IALU_ALL_ONES; // RL16
    for (int i = 0; i < `IALU_WORD; i++) begin
      if (scan_word[i]) begin
        first_index = {27'h0000000, 5'(i)}; // RL18
      end
    end
  end

  ialu_divider u_divider (
    .clock(clock),
    .srst(srst),
    .start(div_start),
    .signed_mode(is_div_s),
    .dividend(source_a),
    .divisor(source_b),
    .done(div_done),
    .quotient(div_quotient),
    .remainder(div_remainder)
  );

  // destination and source-b result selection: one-hot decode gates each candidate word
  wire is_shl = is_sll_c | is_sll_v;
  wire is_shr = is_srl_c | is_srl_v;
  wire is_sar = is_sra_c | is_sra_v;
  wire is_find = is_ff_one | is_ff_zero;
  wire dest_op = is_slt | is_and | is_or | is_xor | is_nor |
    is_shl | is_shr | is_sar | is_rd_up | is_rd_lo | is_find;
  wire [31:0] pick_word =
    ({32{is_slt}} & less_word) | // RL1
    ({32{is_and}} & and_word) | // RL2
    ({32{is_or}} & or_word) | // RL2
    ({32{is_xor}} & xor_word) | // RL2
    ({32{is_nor}} & nor_word) | // RL2
    ({32{is_shl}} & shl_word) | // RL3 RL6
    ({32{is_shr}} & shr_word) | // RL4 RL6
    ({32{is_sar}} & sar_word) | // RL5 RL6
    ({32{is_rd_up}} & upper_q) | // RL11
    ({32{is_rd_lo}} & lower_q) | // RL11
    ({32{is_circ}} & circ_result) | // RL14
    ({32{is_find}} & first_index); // RL15

  // unmapped codes hit no decode line and give no strobe
  assign to_dest_d = take & dest_op;
  assign to_source_b_d = take & is_circ; // RL14
  assign result_valid_d = to_dest_d | to_source_b_d;
  assign result_d = result_valid_d ? pick_word : `IALU_RST_WORD;

  // result pair: datapath writes win over translation-buffer writes
  always_comb begin
    upper_d = upper_q;
    lower_d = lower_q;
    if (tlb_write_upper) begin
      upper_d = tlb_write_data; // RL13
    end
    if (tlb_write_lower) begin
      lower_d = tlb_write_data; // RL13
    end
    if (div_done) begin
      upper_d = div_remainder; // RL9 RL10
      lower_d = div_quotient; // RL9 RL10
    end else if (take & is_mul) begin
      upper_d = prod_word[63:32]; // RL17
      lower_d = prod_word[31:0]; // RL17
    end else if (take & is_wr_up) begin
      upper_d = source_a; // RL12
    end else if (take & is_wr_lo) begin
      lower_d = source_a; // RL12
    end
  end

  assign busy_d = div_start | (busy_q & ~div_done);

  always_ff @(posedge clock) begin
    if (srst) begin
      busy_q <= 1'b0;
      result_valid_q <= 1'b0;
      to_dest_q <= 1'b0;
      to_source_b_q <= 1'b0;
      result_q <= `IALU_RST_WORD;
      upper_q <= `IALU_RST_WORD;
      lower_q <= `IALU_RST_WORD;
    end else begin
      busy_q <= busy_d;
      result_valid_q <= result_valid_d;
      to_dest_q <= to_dest_d;
      to_source_b_q <= to_source_b_d;
      result_q <= result_d;
      upper_q <= upper_d; // RL13
      lower_q <= lower_d; // RL13
    end
  end

  assign busy = busy_q;
  assign result_valid = result_valid_q;
  assign result_to_dest = to_dest_q;
  assign result_to_source_b = to_source_b_q;
  assign result_data = result_q;
  assign upper_result = upper_q;
  assign lower_result = lower_q;
endmodule
`default_nettype wire

// >>> core/ialu_divider.sv
// iterative restoring divider, one quotient bit per clock
`timescale 1ns/1ps
`default_nettype none
`include "ialu_params.svh"
module ialu_divider (
  input wire logic clock,
  input wire logic srst,
  input wire logic start,
  input wire logic signed_mode,
  input wire logic [31:0] dividend,
  input wire logic [31:0] divisor,
  output logic done,
  output logic [31:0] quotient,
  output logic [31:0] remainder
);
  logic run_q;
  logic done_q;
  logic neg_quo_q;
  logic neg_rem_q;
  logic [5:0] count_q;
  logic [31:0] quo_q;
  logic [31:0] rem_q;
  logic [31:0] div_q;
  wire a_neg = signed_mode & dividend[31];
  wire b_neg = signed_mode & divisor[31];
  wire [31:0] a_mag = a_neg ? 32'(-dividend) : dividend;
  wire [31:0] b_mag = b_neg ? 32'(-divisor) : divisor;
  wire [32:0] shifted = {rem_q, quo_q[31]};
  wire step_fits = shifted >= {1'b0, div_q};
  wire [32:0] diff = shifted - {1'b0, div_q};
  wire [31:0] rem_next = step_fits ? diff[31:0] : shifted[31:0];
  wire last_step = run_q && (count_q == `IALU_DIV_LAST);

  always_ff @(posedge clock) begin
    if (srst) begin
      run_q <= 1'b0;
      done_q <= 1'b0;
      count_q <= 6'h00;
      neg_quo_q <= 1'b0;
      neg_rem_q <= 1'b0;
      quo_q <= `IALU_RST_WORD;
      rem_q <= `IALU_RST_WORD;
      div_q <= `IALU_RST_WORD;
    end else if (start) begin
      run_q <= 1'b1;
      done_q <= 1'b0;
      count_q <= 6'h00;
      neg_quo_q <= a_neg ^ b_neg;
      neg_rem_q <= a_neg;
      quo_q <= a_mag;
      rem_q <= `IALU_RST_WORD;
      div_q <= b_mag;
    end else begin
      done_q <= last_step;
      if (run_q) begin
        rem_q <= rem_next;
        quo_q <= {quo_q[30:0], step_fits};
        count_q <= 6'(count_q + 6'h01);
        run_q <= ~last_step;
      end
    end
  end

  // remainder takes the dividend's sign
  assign done = done_q;
  assign quotient = neg_quo_q ? 32'(-quo_q) : quo_q;
  assign remainder = neg_rem_q ? 32'(-rem_q) : rem_q;
endmodule
`default_nettype wire

// >>> include/ialu_params.svh
// constants for the integer execution datapath
`ifndef IALU_PARAMS_SVH
`define IALU_PARAMS_SVH
`define IALU_WORD 32
`define IALU_SHIFT_BITS 5
`define IALU_IMM_BITS 16
`define IALU_DIV_STEPS 6'h20
`define IALU_DIV_LAST 6'h1F
`define IALU_ALL_ONES 32'hFFFFFFFF
`define IALU_RST_WORD 32'h00000000
`define IALU_LESS_TRUE 32'h00000001
`endif

// >>> include/ialu_pkg.sv
// operation codes of the integer execution datapath
package ialu_pkg;
  typedef enum logic [4:0] {
    ialu_op_unsigned_less_compare,
    ialu_op_and,
    ialu_op_or,
    ialu_op_exclusive_or_op,
    ialu_op_not_or_op,
    ialu_op_shift_left_const,
    ialu_op_logical_right_const,
    ialu_op_arith_right_const,
    ialu_op_shift_left_var,
    ialu_op_logical_right_var,
    ialu_op_arith_right_var,
    ialu_op_signed_product_op,
    ialu_op_unsigned_product_op,
    ialu_op_signed_quotient_op,
    ialu_op_unsigned_quotient_op,
    ialu_op_read_upper_result,
    ialu_op_read_lower_result,
    ialu_op_write_upper_result,
    ialu_op_write_lower_result,
    ialu_op_circular_add_imm,
    ialu_op_find_first_one,
    ialu_op_find_first_zero
  } ialu_op_t;
endpackage

// >>> tb/ialu_monitor.sv
// concurrent checks on the integer datapath ports
`timescale 1ns/1ps
`default_nettype none
module ialu_monitor (
  input wire logic clock,
  input wire logic srst,
  input wire logic op_valid,
  input wire ialu_pkg::ialu_op_t op_code,
  input wire logic [31:0] source_a,
  input wire logic [31:0] source_b,
  input wire logic [4:0] shift_amount_field,
  input wire logic busy,
  input wire logic [31:0] result_data,
  input wire logic [31:0] upper_result,
  input wire logic [31:0] lower_result
);
  wire logic take;
  assign take = op_valid && !busy;
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  sequence div_take;
    take && (op_code == ialu_pkg::ialu_op_signed_quotient_op ||
      op_code == ialu_pkg::ialu_op_unsigned_quotient_op);
  endsequence
  sequence div_run;
    busy [*8] ##25 busy ##1 !busy;
  endsequence
  AST_LESS: assert property (take && op_code == ialu_pkg::ialu_op_unsigned_less_compare |=>
    result_data == {31'h0, $past(source_a) < $past(source_b)}) else $error("less result");
  AST_AND: assert property (take && op_code == ialu_pkg::ialu_op_and |=>
    result_data == ($past(source_a) & $past(source_b))) else $error("and result");
  AST_SHL: assert property (take && op_code == ialu_pkg::ialu_op_shift_left_const |=>
    result_data == $past(source_b) << $past(shift_amount_field)) else $error("shift result");
  AST_ARITH_RIGHT_VAR: assert property (take && op_code == ialu_pkg::ialu_op_arith_right_var |=>
    $signed(result_data) == ($signed($past(source_b)) >>> $past(source_a[4:0])))
    else $error("arith_right_var result");
  AST_MULU: assert property (take && op_code == ialu_pkg::ialu_op_unsigned_product_op |=>
    {upper_result, lower_result} == {32'h0, $past(source_a)} * {32'h0, $past(source_b)})
    else $error("product pair");
  AST_RDHI: assert property (take && op_code == ialu_pkg::ialu_op_read_upper_result |=>
    result_data == $past(upper_result)) else $error("read upper");
  AST_WRHI: assert property (take && op_code == ialu_pkg::ialu_op_write_upper_result |=>
    upper_result == $past(source_a)) else $error("write upper");
  AST_DIVRUN: assert property (div_take |=> div_run)
    else $error("divide busy span");
  AST_FFNONE: assert property (take && op_code == ialu_pkg::ialu_op_find_first_one &&
    source_a == 32'h0 |=> result_data == 32'hFFFFFFFF) else $error("no hit value");
endmodule
bind ialu_core ialu_monitor mon (.clock, .srst, .op_valid, .op_code, .source_a, .source_b,
  .shift_amount_field, .busy, .result_data, .upper_result, .lower_result);
`default_nettype wire

// >>> tb/ialu_regfile_model.sv
// register file sink capturing datapath writes
`timescale 1ns/1ps
`default_nettype none
module ialu_regfile_model (
  input wire logic clock,
  input wire logic srst,
  input wire logic result_valid,
  input wire logic result_to_dest,
  input wire logic result_to_source_b,
  input wire logic [31:0] result_data,
  output logic [31:0] dest_word,
  output logic [31:0] srcb_word
);
  always_ff @(posedge clock) begin
    if (srst) begin
      dest_word <= 32'h0;
      srcb_word <= 32'h0;
    end else if (result_valid && result_to_dest) begin
      dest_word <= result_data;
    end else if (result_valid && result_to_source_b) begin
      srcb_word <= result_data;
    end
  end
endmodule
`default_nettype wire

// >>> tb/integer_alu_shift_muldiv_test.sv
// self-checking bench for the integer datapath
`timescale 1ns/1ps
`default_nettype none
module integer_alu_shift_muldiv_test;
  logic clock = 1'b0, srst = 1'b1, op_valid = 1'b0;
  ialu_pkg::ialu_op_t op_code = ialu_pkg::ialu_op_and;
  logic [31:0] source_a = 32'h0, source_b = 32'h0, tlb_write_data = 32'h0;
  logic [4:0] shift_amount_field = 5'h0, circular_mask = 5'h0;
  logic [15:0] immediate = 16'h0;
  logic tlb_write_upper = 1'b0, tlb_write_lower = 1'b0;
  logic busy, result_valid, result_to_dest, result_to_source_b;
  logic [31:0] result_data, upper_result, lower_result, dest_word, srcb_word;
  int n_errors = 0, comparisons = 0;
  always #4 clock = ~clock;
  ialu_core dut (.clock, .srst, .op_valid, .op_code, .source_a, .source_b, .shift_amount_field,
    .immediate, .circular_mask, .tlb_write_upper, .tlb_write_lower, .tlb_write_data, .busy,
    .result_valid, .result_to_dest, .result_to_source_b, .result_data, .upper_result,
    .lower_result);
  ialu_regfile_model rf (.clock, .srst, .result_valid, .result_to_dest, .result_to_source_b,
    .result_data, .dest_word, .srcb_word);
  task automatic wrap_up;
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk_w(input string nm, input logic [31:0] e, g);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic issue(input ialu_pkg::ialu_op_t op, input logic [31:0] a, b);
    @(negedge clock);
    op_code = op;
    source_a = a;
    source_b = b;
    op_valid = 1'b1;
    @(negedge clock);
    op_valid = 1'b0;
  endtask
  task automatic rd(input ialu_pkg::ialu_op_t op, input logic [31:0] a, b, e);
    issue(op, a, b);
    chk_w("dest strobe", 32'h1, {31'h0, result_valid && result_to_dest});
    chk_w("result", e, result_data);
    @(negedge clock);
    chk_w("dest word", e, dest_word);
  endtask
  task automatic t_logic;
    rd(ialu_pkg::ialu_op_unsigned_less_compare, 32'hFFFFFFFF, 32'h1, 32'h0);
    rd(ialu_pkg::ialu_op_unsigned_less_compare, 32'h1, 32'hFFFFFFFF, 32'h1);
    rd(ialu_pkg::ialu_op_unsigned_less_compare, 32'h5, 32'h5, 32'h0);
    rd(ialu_pkg::ialu_op_and, 32'hF0F0F0F0, 32'hFF00FF00, 32'hF000F000);
    rd(ialu_pkg::ialu_op_or, 32'hF0F0F0F0, 32'hFF00FF00, 32'hFFF0FFF0);
    rd(ialu_pkg::ialu_op_exclusive_or_op, 32'hF0F0F0F0, 32'hFF00FF00, 32'h0FF00FF0);
    rd(ialu_pkg::ialu_op_not_or_op, 32'hF0F0F0F0, 32'hFF00FF00, 32'h000F000F);
  endtask
  task automatic t_shift;
    shift_amount_field = 5'h1F;
    rd(ialu_pkg::ialu_op_shift_left_const, 32'h0, 32'h3, 32'h80000000);
    rd(ialu_pkg::ialu_op_logical_right_const, 32'h0, 32'h80000000, 32'h1);
    rd(ialu_pkg::ialu_op_arith_right_const, 32'h0, 32'h80000000, 32'hFFFFFFFF);
    rd(ialu_pkg::ialu_op_shift_left_var, 32'hFFFFFFE4, 32'h8000000F, 32'h000000F0);
    rd(ialu_pkg::ialu_op_logical_right_var, 32'hFFFFFFE4, 32'h8000000F, 32'h08000000);
    rd(ialu_pkg::ialu_op_arith_right_var, 32'hFFFFFFE4, 32'h8000000F, 32'hF8000000);
  endtask
  task automatic t_move;
    @(negedge clock);
    tlb_write_data = 32'h0000ABCD;
    tlb_write_upper = 1'b1;
    tlb_write_lower = 1'b1;
    @(negedge clock);
    tlb_write_upper = 1'b0;
    tlb_write_lower = 1'b0;
    chk_w("tlb pair", 32'h0000ABCD, upper_result & lower_result);
    issue(ialu_pkg::ialu_op_signed_product_op, 32'hFFFFFFFE, 32'h3);
    chk_w("smul hi", 32'hFFFFFFFF, upper_result);
    chk_w("smul lo", 32'hFFFFFFFA, lower_result);
    chk_w("smul strobe", 32'h0, {31'h0, result_valid});
    issue(ialu_pkg::ialu_op_unsigned_product_op, 32'hFFFFFFFE, 32'h3);
    chk_w("umul hi", 32'h2, upper_result);
    rd(ialu_pkg::ialu_op_read_upper_result, 32'h0, 32'h0, 32'h2);
    rd(ialu_pkg::ialu_op_read_lower_result, 32'h0, 32'h0, 32'hFFFFFFFA);
    issue(ialu_pkg::ialu_op_write_upper_result, 32'h1234, 32'h0);
    issue(ialu_pkg::ialu_op_write_lower_result, 32'h5678, 32'h0);
    chk_w("mv hi", 32'h1234, upper_result);
    chk_w("mv lo", 32'h5678, lower_result);
  endtask
  task automatic t_div(input logic sgn, input logic [31:0] a, b, q, r);
    int i;
    issue(sgn ? ialu_pkg::ialu_op_signed_quotient_op : ialu_pkg::ialu_op_unsigned_quotient_op,
      a, b);
    chk_w("busy", 32'h1, {31'h0, busy});
    issue(ialu_pkg::ialu_op_write_upper_result, 32'h0BAD, 32'h0);
    for (i = 0; i < 40 && busy !== 1'b0; i++) @(negedge clock);
    if (i == 40) begin
      n_errors++;
      wrap_up;
    end
    chk_w("quotient", q, lower_result);
    chk_w("remainder", r, upper_result);
  endtask
  task automatic t_circ(input logic [31:0] a, input logic [15:0] imm, input logic [4:0] m,
    input logic [31:0] e);
    immediate = imm;
    circular_mask = m;
    issue(ialu_pkg::ialu_op_circular_add_imm, a, 32'h0);
    chk_w("srcb strobe", 32'h1, {31'h0, result_valid && result_to_source_b});
    chk_w("circ", e, result_data);
    @(negedge clock);
    chk_w("srcb word", e, srcb_word);
  endtask
  task automatic t_reset;
    issue(ialu_pkg::ialu_op_unsigned_quotient_op, 32'h64, 32'h7);
    srst = 1'b1;
    @(negedge clock);
    srst = 1'b0;
    chk_w("reset busy", 32'h0, {31'h0, busy});
    chk_w("reset pair", 32'h0, upper_result | lower_result);
    rd(ialu_pkg::ialu_op_and, 32'h0000000F, 32'h00000003, 32'h00000003);
  endtask
  task automatic t_find;
    rd(ialu_pkg::ialu_op_find_first_one, 32'h80000001, 32'h0, 32'h1F);
    rd(ialu_pkg::ialu_op_find_first_one, 32'h00010000, 32'h0, 32'h10);
    rd(ialu_pkg::ialu_op_find_first_one, 32'h0, 32'h0, 32'hFFFFFFFF);
    rd(ialu_pkg::ialu_op_find_first_zero, 32'hFFFF7FFF, 32'h0, 32'hF);
    rd(ialu_pkg::ialu_op_find_first_zero, 32'hFFFFFFFF, 32'h0, 32'hFFFFFFFF);
  endtask
  initial begin
    repeat (3) @(negedge clock);
    srst = 1'b0;
    chk_w("reset pair", 32'h0, upper_result | lower_result | result_data);
    t_logic;
    t_shift;
    t_move;
    t_div(1'b1, 32'hFFFFFFF9, 32'h2, 32'hFFFFFFFD, 32'hFFFFFFFF);
    t_div(1'b0, 32'h64, 32'h7, 32'hE, 32'h2);
    t_reset;
    t_circ(32'h123456FF, 16'h0001, 5'h8, 32'h12345600);
    t_circ(32'h12345600, 16'hFFFF, 5'h4, 32'h1234560F);
    t_circ(32'h12345600, 16'hFFFF, 5'h0, 32'h12345600);
    t_find;
    wrap_up;
  end
endmodule
`default_nettype wire
